// ### bgr_consts.vh
`ifndef BGR_CONSTS_VH
`define BGR_CONSTS_VH
// ------------------------------------------------------------
// Command codes
// ------------------------------------------------------------
`define BGR_CMD_HOST_RATE      8'h04
`define BGR_CMD_TIME_TO_FULL   8'h05
`define BGR_CMD_TIME_TO_EMPTY  8'h06
`define BGR_CMD_LOAD_OK        8'h07
`define BGR_CMD_TEMPERATURE    8'h08
`define BGR_CMD_VOLTAGE        8'h09
`define BGR_CMD_CURRENT        8'h0a
`define BGR_CMD_MEAN_CURRENT   8'h0b
`define BGR_CMD_ERROR_MARGIN   8'h0c
`define BGR_CMD_PCT_LEARNED    8'h0d
`define BGR_CMD_PCT_DESIGN     8'h0e
`define BGR_CMD_CAP_LEFT       8'h0f
`define BGR_CMD_CAP_FULL       8'h10
// ------------------------------------------------------------
// Field positions, values and reset values
// ------------------------------------------------------------
`define BGR_MODE_CAP_UNIT_BIT  15
`define BGR_RATE_RESET         16'h0000
`define BGR_TIME_INVALID       16'hffff
`define BGR_TIME_MAX           16'hfffe
`define BGR_BOOL_TRUE          16'h0001
`define BGR_BOOL_FALSE         16'h0000
`define BGR_MARGIN_RESET       7'd100
`define BGR_MARGIN_LEARNED     7'd2
`define BGR_MARGIN_CLAMPED     7'd8
`define BGR_MARGIN_VOLT_FIX    7'd25
`define BGR_MARGIN_MIN         7'd2
`define BGR_MARGIN_MAX         7'd100
`define BGR_MARGIN_STEP_CYCLES 2'd3
`define BGR_PCT_MAX            16'd100
`define BGR_VOLT_MAX           16'd20000
`define BGR_ERR_OK             3'h0
`define BGR_ERR_NOT_READY      3'h1
// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define BGR_CLK_MHZ            250
`define BGR_RECALC_MS          1300
`define BGR_REFRESH_MS         20000
`define BGR_LOAD_HOLD_S        10
`define BGR_MS_CYCLES          (`BGR_CLK_MHZ * 1000)
`endif

// ### bgr_report_bank.v
`timescale 1ns/100ps
`include "bgr_consts.vh"
module bgr_report_bank #(
  parameter        RECALC_CYCLES  = `BGR_RECALC_MS * `BGR_MS_CYCLES,
  parameter [32:0] REFRESH_CYCLES = 33'd1 * `BGR_REFRESH_MS * `BGR_MS_CYCLES,
  parameter MS_CYCLES      = `BGR_MS_CYCLES
) (
  input  wire        clk,
  input  wire        srst,
  input  wire        cmdValid,
  input  wire        cmdWrite,
  input  wire [7:0]  cmdCode,
  input  wire [15:0] cmdWdata,
  output reg         cmdDone,
  output reg         cmdAck,
  output reg  [15:0] cmdRdata,
  output reg  [2:0]  statusErrCode,
  output reg  [15:0] hostRateValue,
  input  wire        capUnitSel,
  input  wire [15:0] measTemperature,
  input  wire [15:0] measVoltage,
  input  wire [15:0] measCurrent,
  input  wire [15:0] capLeftMah,
  input  wire [15:0] capLeftCwh,
  input  wire [15:0] capFullMah,
  input  wire [15:0] capFullCwh,
  input  wire [15:0] nominalCapacity,
  input  wire        learnDone,
  input  wire        learnClamped,
  input  wire        cycleTallyInc,
  input  wire        voltCorrection
);

// ------------------------------------------------------------
// Pin input synchronisers
// ------------------------------------------------------------
reg  [7:0] syncA_reg;
reg  [7:0] syncB_reg;
reg        learnPrev_reg;
reg        tallyPrev_reg;
reg        voltPrev_reg;
wire       unitBit    = syncB_reg[0];
wire       learnEvt   = syncB_reg[1] & ~learnPrev_reg;
wire       clampedLvl = syncB_reg[2];
wire       tallyEvt   = syncB_reg[3] & ~tallyPrev_reg;
wire       voltEvt    = syncB_reg[4] & ~voltPrev_reg;

always @(posedge clk)
begin
  if (srst)
  begin
    syncA_reg     <= 8'h00;
    syncB_reg     <= 8'h00;
    learnPrev_reg <= 1'b0;
    tallyPrev_reg <= 1'b0;
    voltPrev_reg  <= 1'b0;
  end
  else
  begin
    syncA_reg     <= {3'h0, voltCorrection, cycleTallyInc, learnClamped, learnDone, capUnitSel};
    syncB_reg     <= syncA_reg;
    learnPrev_reg <= syncB_reg[1];
    tallyPrev_reg <= syncB_reg[3];
    voltPrev_reg  <= syncB_reg[4];
  end
end

// ------------------------------------------------------------
// Measurement sampling
// ------------------------------------------------------------
// Measurement words change slowly; two flops per bit settle them.
reg [15:0] mA_reg [0:8];
reg [15:0] mB_reg [0:8];
wire [15:0] mIn [0:8];
assign mIn[0] = measTemperature;
assign mIn[1] = measVoltage;
assign mIn[2] = measCurrent;
assign mIn[3] = capLeftMah;
assign mIn[4] = capLeftCwh;
assign mIn[5] = capFullMah;
assign mIn[6] = capFullCwh;
assign mIn[7] = nominalCapacity;
assign mIn[8] = 16'h0000;

genvar gi;
generate
  for (gi = 0; gi < 9; gi = gi + 1)
  begin : gSync
    always @(posedge clk)
    begin
      if (srst)
      begin
        mA_reg[gi] <= 16'h0000;
        mB_reg[gi] <= 16'h0000;
      end
      else
      begin
        mA_reg[gi] <= mIn[gi];
        mB_reg[gi] <= mA_reg[gi];
      end
    end
  end
endgenerate

wire [15:0] tempW    = mB_reg[0];
wire [15:0] voltW    = (mB_reg[1] > `BGR_VOLT_MAX) ? `BGR_VOLT_MAX : mB_reg[1];
wire [15:0] currW    = mB_reg[2];
wire [15:0] capLeftW = unitBit ? mB_reg[4] : mB_reg[3];
wire [15:0] capFullW = unitBit ? mB_reg[6] : mB_reg[5];
wire [15:0] nomW     = mB_reg[7];

// ------------------------------------------------------------
// Mean current: exponential one-minute filter seeded at start
// ------------------------------------------------------------
reg  [31:0] msCnt_reg;
reg  [15:0] secTick_reg;
reg         seeded_reg;
reg  [31:0] meanAcc_reg;
wire        msTick   = (msCnt_reg == MS_CYCLES - 1);
wire        secTick  = msTick && (secTick_reg == 16'd999);
wire [31:0] currSx   = {{16{currW[15]}}, currW};
wire [31:0] meanSx   = {{6{meanAcc_reg[31]}}, meanAcc_reg[31:6]};

always @(posedge clk)
begin
  if (srst)
  begin
    msCnt_reg   <= 32'h0;
    secTick_reg <= 16'h0;
    seeded_reg  <= 1'b0;
    meanAcc_reg <= 32'h0;
  end
  else
  begin
    msCnt_reg <= msTick ? 32'h0 : msCnt_reg + 32'h1;
    if (msTick)
      secTick_reg <= secTick ? 16'h0 : secTick_reg + 16'h1;
    if (!seeded_reg && secTick)
    begin
      seeded_reg  <= 1'b1;
      // The seed keeps the sign of the current, so discharge means stay negative.
      meanAcc_reg <= {{10{currW[15]}}, currW, 6'h00};
    end
    else if (secTick)
      meanAcc_reg <= meanAcc_reg - meanSx + currSx;
  end
end

// Before the filter seeds, the live current stands in, so the word is meaningful.
wire [15:0] meanW = seeded_reg ? meanAcc_reg[21:6] : currW;

// ------------------------------------------------------------
// Percentages
// ------------------------------------------------------------
wire [22:0] leftX100 = capLeftW * 7'd100;
wire [22:0] pctLearnRaw = (capFullW == 16'h0) ? 23'h0 : leftX100 / capFullW;
wire [15:0] pctLearned = (pctLearnRaw > 23'd100) ? `BGR_PCT_MAX : pctLearnRaw[15:0];
wire [22:0] pctDesRaw = (nomW == 16'h0) ? 23'h0 : leftX100 / nomW;
wire [15:0] pctDesign = (pctDesRaw > 23'hffff) ? 16'hffff : pctDesRaw[15:0];

// ------------------------------------------------------------
// Error margin bookkeeping
// ------------------------------------------------------------
reg [6:0] margin_reg;
reg [6:0] margin_next;
reg [1:0] tally_reg;

always @*
begin
  margin_next = margin_reg;
  if (voltEvt)
    margin_next = `BGR_MARGIN_VOLT_FIX;
  else if (learnEvt && !clampedLvl)
    margin_next = `BGR_MARGIN_LEARNED;
  else if (learnEvt)
  begin
    if (margin_reg >= `BGR_MARGIN_CLAMPED)
      margin_next = `BGR_MARGIN_CLAMPED;
  end
  else if (tallyEvt && tally_reg == `BGR_MARGIN_STEP_CYCLES && margin_reg < `BGR_MARGIN_MAX)
    margin_next = margin_reg + 7'd1;
end

always @(posedge clk)
begin
  if (srst)
  begin
    margin_reg <= `BGR_MARGIN_RESET;
    tally_reg  <= 2'd0;
  end
  else
  begin
    margin_reg <= (margin_next < `BGR_MARGIN_MIN) ? `BGR_MARGIN_MIN : margin_next;
    if (learnEvt)
      tally_reg <= 2'd0;
    else if (tallyEvt)
      tally_reg <= tally_reg + 2'd1;
  end
end

// ------------------------------------------------------------
// Rate-based predictions
// ------------------------------------------------------------
reg  [31:0] busyCnt_reg;
reg  [32:0] refreshCnt_reg;
reg         busy_reg;
reg  [15:0] ttFull_reg;
reg  [15:0] ttEmpty_reg;
reg  [15:0] loadOk_reg;
wire        rateWr   = cmdValid && cmdWrite && cmdCode == `BGR_CMD_HOST_RATE;
wire        rateNeg  = hostRateValue[15];
wire        ratePos  = !rateNeg && hostRateValue != 16'h0;
wire [15:0] rateMag  = rateNeg ? (~hostRateValue + 16'h1) : hostRateValue;
wire [15:0] roomW    = (capFullW > capLeftW) ? capFullW - capLeftW : 16'h0;
// Minutes = capacity * 60 / rate; 1-minute granularity.
wire [21:0] toFull60 = roomW * 6'd60;
wire [21:0] toEmp60  = capLeftW * 6'd60;
wire [21:0] fullMin  = (rateMag == 16'h0) ? 22'h0 : toFull60 / rateMag;
wire [21:0] empMin   = (rateMag == 16'h0) ? 22'h0 : toEmp60 / rateMag;
// Load is fine if remaining capacity covers the extra rate for 10 s (cap*3600 >= rate*10).
wire [27:0] capSec   = capLeftW * 12'd3600;
wire [27:0] needSec  = rateMag * 4'd10;
wire        recalcGo = busy_reg && busyCnt_reg == RECALC_CYCLES - 1;
wire        refreshGo = refreshCnt_reg == REFRESH_CYCLES - 33'd1;

// ------------------------------------------------------------
// Stored rate value
// ------------------------------------------------------------
always @(posedge clk)
begin
  if (srst)
    hostRateValue <= `BGR_RATE_RESET;
  else if (rateWr)
    hostRateValue <= cmdWdata;
end

// ------------------------------------------------------------
// Not-ready window
// ------------------------------------------------------------
// The window closes on the edge that loads the fresh words, so a read taken
// on that same edge is still refused and no read ever sees a stale word.
always @(posedge clk)
begin
  if (srst)
  begin
    busy_reg    <= 1'b0;
    busyCnt_reg <= 32'h0;
  end
  else if (rateWr)
  begin
    busy_reg    <= 1'b1;
    busyCnt_reg <= 32'h0;
  end
  else if (busy_reg)
  begin
    busyCnt_reg <= busyCnt_reg + 32'h1;
    if (recalcGo)
      busy_reg <= 1'b0;
  end
end

// ------------------------------------------------------------
// Periodic refresh timer
// ------------------------------------------------------------
// Twenty seconds of clock cycles does not fit in 32 bits.
always @(posedge clk)
begin
  if (srst || refreshGo)
    refreshCnt_reg <= 33'h0;
  else
    refreshCnt_reg <= refreshCnt_reg + 33'h1;
end

// ------------------------------------------------------------
// Prediction words
// ------------------------------------------------------------
always @(posedge clk)
begin
  if (srst)
  begin
    ttFull_reg  <= `BGR_TIME_INVALID;
    ttEmpty_reg <= `BGR_TIME_INVALID;
    loadOk_reg  <= `BGR_BOOL_TRUE;
  end
  else if (!rateWr && (recalcGo || refreshGo))
  begin
    ttFull_reg  <= !ratePos ? `BGR_TIME_INVALID :
                   (fullMin > 22'hfffe) ? `BGR_TIME_MAX : fullMin[15:0];
    ttEmpty_reg <= !rateNeg ? `BGR_TIME_INVALID :
                   (empMin > 22'hfffe) ? `BGR_TIME_MAX : empMin[15:0];
    loadOk_reg  <= (!rateNeg || capSec >= needSec) ? `BGR_BOOL_TRUE : `BGR_BOOL_FALSE;
  end
end

// ------------------------------------------------------------
// Command port
// ------------------------------------------------------------
reg        ackN;
reg [15:0] dataN;
wire       isPred = cmdCode == `BGR_CMD_TIME_TO_FULL || cmdCode == `BGR_CMD_TIME_TO_EMPTY ||
                    cmdCode == `BGR_CMD_LOAD_OK;

always @*
begin
  ackN  = 1'b1;
  dataN = 16'h0000;
  case (cmdCode)
    `BGR_CMD_HOST_RATE:     dataN = hostRateValue;
    `BGR_CMD_TIME_TO_FULL:  dataN = ttFull_reg;
    `BGR_CMD_TIME_TO_EMPTY: dataN = ttEmpty_reg;
    `BGR_CMD_LOAD_OK:       dataN = loadOk_reg;
    `BGR_CMD_TEMPERATURE:   dataN = tempW;
    `BGR_CMD_VOLTAGE:       dataN = voltW;
    `BGR_CMD_CURRENT:       dataN = currW;
    `BGR_CMD_MEAN_CURRENT:  dataN = meanW;
    `BGR_CMD_ERROR_MARGIN:  dataN = {9'h0, margin_reg};
    `BGR_CMD_PCT_LEARNED:   dataN = pctLearned;
    `BGR_CMD_PCT_DESIGN:    dataN = pctDesign;
    `BGR_CMD_CAP_LEFT:      dataN = capLeftW;
    `BGR_CMD_CAP_FULL:      dataN = capFullW;
    default:                ackN  = 1'b0;
  endcase
  if (cmdWrite && cmdCode != `BGR_CMD_HOST_RATE)
    ackN = 1'b0;
  if (!cmdWrite && isPred && (busy_reg || rateWr))
  begin
    ackN  = 1'b0;
    dataN = 16'h0000;
  end
end

always @(posedge clk)
begin
  if (srst)
  begin
    cmdDone       <= 1'b0;
    cmdAck        <= 1'b0;
    cmdRdata      <= 16'h0000;
    statusErrCode <= `BGR_ERR_OK;
  end
  else
  begin
    cmdDone <= cmdValid;
    cmdAck  <= cmdValid && ackN;
    if (cmdValid && !cmdWrite)
      cmdRdata <= ackN ? dataN : 16'h0000;
    if (cmdValid && !cmdWrite && isPred && (busy_reg || rateWr))
      statusErrCode <= `BGR_ERR_NOT_READY;
    else if (cmdValid && ackN)
      statusErrCode <= `BGR_ERR_OK;
  end
end

endmodule // bgr_report_bank

// ### bgr_report_props.sv
`timescale 1ns/100ps
module bgr_report_props (
  input wire        clk,
  input wire        srst,
  input wire        cmdValid,
  input wire        cmdWrite,
  input wire [7:0]  cmdCode,
  input wire [15:0] cmdWdata,
  input wire        cmdDone,
  input wire        cmdAck,
  input wire [15:0] cmdRdata,
  input wire [2:0]  statusErrCode,
  input wire [15:0] hostRateValue
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (srst);
  // ----------------------------------------
  // Command sequences
  // ----------------------------------------
  sequence s_rate_wr;
    cmdValid && cmdWrite && cmdCode == 8'h04;
  endsequence
  sequence s_pred_rd;
    cmdValid && !cmdWrite && cmdCode >= 8'h05 && cmdCode <= 8'h07;
  endsequence
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_done;
    cmdValid |=> cmdDone;
  endproperty
  property p_quiet;
    !cmdValid |=> !cmdDone && !cmdAck;
  endproperty
  property p_refuse;
    s_rate_wr ##[1:40] s_pred_rd |=> !cmdAck && cmdRdata == 16'h0000 && statusErrCode == 3'h1;
  endproperty
  property p_rate;
    s_rate_wr |=> cmdAck && hostRateValue == $past(cmdWdata);
  endproperty
  property p_bad_wr;
    cmdValid && cmdWrite && cmdCode != 8'h04 |=> !cmdAck && $stable(statusErrCode);
  endproperty
  property p_margin;
    cmdValid && !cmdWrite && cmdCode == 8'h0c |=> cmdAck && cmdRdata >= 16'd2
      && cmdRdata <= 16'd100;
  endproperty
  property p_load_ok;
    cmdValid && !cmdWrite && cmdCode == 8'h07 && !hostRateValue[15] ##1 cmdAck
      |-> cmdRdata == 16'h0001;
  endproperty
  property p_ok_err;
    cmdAck |-> statusErrCode == 3'h0;
  endproperty
  property p_unknown;
    cmdValid && (cmdCode < 8'h04 || cmdCode > 8'h10) |=> !cmdAck;
  endproperty
  a_done: assert property (p_done) else $error("no answer one cycle after command");
  a_quiet: assert property (p_quiet) else $error("answer without command");
  a_refuse: assert property (p_refuse) else $error("prediction read not refused");
  a_rate: assert property (p_rate) else $error("rate value not stored");
  a_bad_wr: assert property (p_bad_wr) else $error("bad write acknowledged");
  a_margin: assert property (p_margin) else $error("margin out of range");
  a_load_ok: assert property (p_load_ok) else $error("load word false at rate >= 0");
  a_ok_err: assert property (p_ok_err) else $error("error code not cleared");
  a_unknown: assert property (p_unknown) else $error("unknown code acknowledged");
endmodule // bgr_report_props

// ### bgr_host_model.sv
`timescale 1ns/100ps
module bgr_host_model (
  input  wire        clk,
  output logic       cmdValid,
  output logic       cmdWrite,
  output logic [7:0] cmdCode,
  output logic [15:0] cmdWdata
);
  initial
  begin
    cmdValid = 1'b0;
    cmdWrite = 1'b0;
    cmdCode = 8'h00;
    cmdWdata = 16'h0000;
  end
  // One word per command; released code and data lines are inverted, cmdWrite is held.
  task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data);
    @(posedge clk);
    cmdValid <= 1'b1;
    cmdWrite <= wr;
    cmdCode <= code;
    cmdWdata <= data;
    @(posedge clk);
    cmdValid <= 1'b0;
    cmdCode <= ~code;
    cmdWdata <= ~data;
  endtask
endmodule // bgr_host_model

// ### test_bgr_report_bank.sv
`timescale 1ns/100ps
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin nMismatch++; \
  $display("BAD t=%0t got %h exp %h", $time, a, b); end end
module test_bgr_report_bank;
  logic        clk = 1'b0, srst = 1'b1, capUnitSel = 1'b0, learnClamped = 1'b0;
  logic [2:0]  evt = 3'h0;
  logic [15:0] mT = 16'h0, mV = 16'h0, mC = 16'h0, lm = 16'h0, lc = 16'h0;
  logic [15:0] fm = 16'h0, fc = 16'h0, nc = 16'h0;
  wire         cmdValid, cmdWrite, cmdDone, cmdAck;
  wire [7:0]   cmdCode;
  wire [15:0]  cmdWdata, cmdRdata, hostRateValue;
  wire [2:0]   statusErrCode;
  logic [17:0] expQ[$];
  logic [17:0] e;
  int          nMismatch = 0, comparisons = 0, cycles = 0;
  always #2 clk = ~clk;
  bgr_host_model bgr_host_model_inst (.clk(clk), .cmdValid(cmdValid), .cmdWrite(cmdWrite),
    .cmdCode(cmdCode), .cmdWdata(cmdWdata));
  bgr_report_bank #(.RECALC_CYCLES(50), .REFRESH_CYCLES(400), .MS_CYCLES(1))
    bgr_report_bank_inst (.clk(clk), .srst(srst), .cmdValid(cmdValid),
    .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWdata(cmdWdata), .cmdDone(cmdDone),
    .cmdAck(cmdAck), .cmdRdata(cmdRdata), .statusErrCode(statusErrCode),
    .hostRateValue(hostRateValue), .capUnitSel(capUnitSel), .measTemperature(mT),
    .measVoltage(mV), .measCurrent(mC), .capLeftMah(lm), .capLeftCwh(lc),
    .capFullMah(fm), .capFullCwh(fc), .nominalCapacity(nc), .learnDone(evt[0]),
    .learnClamped(learnClamped), .cycleTallyInc(evt[1]), .voltCorrection(evt[2]));
  // ----------------------------------------
  // Driver tasks
  // ----------------------------------------
  task automatic waitc(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] code, input logic ack, input logic [15:0] d);
    expQ.push_back({1'b1, ack, d});
    bgr_host_model_inst.xfer(1'b0, code, 16'h0000);
  endtask
  task automatic wr(input logic [7:0] code, input logic [15:0] d, input logic ack);
    expQ.push_back({1'b0, ack, 16'h0000});
    bgr_host_model_inst.xfer(1'b1, code, d);
  endtask
  task automatic errc(input logic [2:0] x);
    @(negedge clk);
    `CHK(statusErrCode, x)
  endtask
  task automatic pulse(input int i);
    evt[i] <= 1'b1;
    waitc(4);
    evt[i] <= 1'b0;
    waitc(5);
  endtask
  task automatic results;
    $display("comparisons %0d mismatches %0d", comparisons, nMismatch);
    if (nMismatch == 0 && comparisons > 0)
      $display("DONE - PASS");
    else
      $display("DONE - FAIL");
    $finish;
  endtask
  // ----------------------------------------
  // Monitor and timeout
  // ----------------------------------------
  always @(negedge clk)
    if (cmdDone === 1'b1)
    begin
      e = expQ.pop_front();
      `CHK(cmdAck, e[16])
      if (e[17])
        `CHK(cmdRdata, e[15:0])
    end
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 6000)
    begin
      nMismatch++;
      results();
    end
  end
  // ----------------------------------------
  // Tests
  // ----------------------------------------
  initial
  begin
    void'($urandom(32'ha075));
    waitc(8);
    srst <= 1'b0;
    mT <= 16'($urandom);
    mV <= 16'($urandom % 20001);
    mC <= 16'($urandom);
    lc <= 16'($urandom);
    fc <= 16'($urandom);
    nc <= 16'd1000;
    lm <= 16'd1200;
    fm <= 16'd2000;
    waitc(4);
    rd(8'h0c, 1'b1, 16'd100);
    rd(8'h05, 1'b1, 16'hffff);
    rd(8'h06, 1'b1, 16'hffff);
    rd(8'h07, 1'b1, 16'h0001);
    rd(8'h0b, 1'b1, mC);
    rd(8'h04, 1'b1, 16'h0000);
    $display("reset values done");
    for (int u = 0; u < 2; u++)
    begin
      capUnitSel <= u[0];
      waitc(4);
      rd(8'h08, 1'b1, mT);
      rd(8'h09, 1'b1, mV);
      rd(8'h0a, 1'b1, mC);
      rd(8'h0f, 1'b1, u ? lc : lm);
      rd(8'h10, 1'b1, u ? fc : fm);
    end
    capUnitSel <= 1'b0;
    rd(8'h20, 1'b0, 16'h0000);
    wr(8'h08, 16'h1234, 1'b0);
    rd(8'h0d, 1'b1, 16'd60);
    rd(8'h0e, 1'b1, 16'd120);
    $display("measurement words done");
    wr(8'h04, 16'hfda8, 1'b1);
    rd(8'h06, 1'b0, 16'h0000);
    errc(3'h1);
    rd(8'h04, 1'b1, 16'hfda8);
    waitc(30);
    wr(8'h04, 16'hfda8, 1'b1);
    waitc(30);
    rd(8'h05, 1'b0, 16'h0000);
    waitc(50);
    rd(8'h06, 1'b1, 16'd120);
    errc(3'h0);
    rd(8'h05, 1'b1, 16'hffff);
    rd(8'h07, 1'b1, 16'h0001);
    lm <= 16'd600;
    waitc(420);
    rd(8'h06, 1'b1, 16'd60);
    wr(8'h04, 16'd300, 1'b1);
    waitc(60);
    rd(8'h05, 1'b1, 16'd280);
    rd(8'h06, 1'b1, 16'hffff);
    lm <= 16'd5;
    wr(8'h04, 16'h8000, 1'b1);
    waitc(60);
    rd(8'h07, 1'b1, 16'h0000);
    rd(8'h06, 1'b1, 16'h0000);
    $display("rate predictions done");
    pulse(0);
    rd(8'h0c, 1'b1, 16'd2);
    for (int k = 0; k < 4; k++)
      pulse(1);
    rd(8'h0c, 1'b1, 16'd3);
    learnClamped <= 1'b1;
    pulse(0);
    rd(8'h0c, 1'b1, 16'd3);
    pulse(2);
    rd(8'h0c, 1'b1, 16'd25);
    pulse(0);
    rd(8'h0c, 1'b1, 16'd8);
    waitc(1500);
    rd(8'h0b, 1'b1, mC);
    waitc(4);
    $display("error margin done");
    results();
  end
endmodule // test_bgr_report_bank
bind bgr_report_bank bgr_report_props bgr_report_props_inst (.clk(clk), .srst(srst),
  .cmdValid(cmdValid), .cmdWrite(cmdWrite), .cmdCode(cmdCode), .cmdWdata(cmdWdata),
  .cmdDone(cmdDone), .cmdAck(cmdAck), .cmdRdata(cmdRdata),
  .statusErrCode(statusErrCode), .hostRateValue(hostRateValue));
